// *** shared/sys_cfg_pkg.sv ***
// Package of offsets, field positions and reset values for the system configuration block.
package sys_cfg_pkg;
  // ==========================================================================
  // Register map
  localparam logic [11:0] cfg_one_off = 12'h000;
  // ==========================================================================
  // Field positions
  localparam int mem_sel_lsb = 0;
  localparam int mem_sel_msb = 1;
  localparam int fmp_lsb = 16;
  localparam int fmp_msb = 19;
  localparam int fmp_count = 4;
  localparam int rsv_hi_lsb = 20;
  // ==========================================================================
  // Reset values
  localparam logic [3:0] fmp_rst = 4'h0;
  localparam logic [1:0] mem_sel_rst = 2'h0;
  localparam logic [11:0] rsv_hi_rst = 12'h000;
  // ==========================================================================
  // Memory seen at address zero.
  typedef enum logic [1:0] {
    map_main_flash = 2'b00,
    map_sys_flash = 2'b01,
    map_sram = 2'b11
  } map_sel_t;
endpackage

// *** core/boot_sel_decode.sv ***
// Decoder from the two-bit memory selection to one-hot memory selects.
`timescale 1ns/1ns
`default_nettype none
module boot_sel_decode
  import sys_cfg_pkg::*;
(
  // Selection field.
  input wire logic [1:0] sel,
  // One-hot result.
  output logic main_flash,
  output logic sys_flash,
  output logic sram
);
  // ==========================================================================
  // Decode
  // A clear low bit always means main flash, whatever the high bit holds.
  always_comb begin
    main_flash = ~sel[0];
    sys_flash = (sel == map_sys_flash);
    sram = (sel == map_sram);
  end
endmodule
`default_nettype wire

// *** core/system_config_unit.sv ***
// System configuration register bank with address-zero memory remap and drive bits.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module system_config_unit
  import sys_cfg_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Boot mode pins.
  input wire logic [1:0] boot_mode,
  // Address-zero memory select.
  output logic map_main_flash_q,
  output logic map_sys_flash_q,
  output logic map_sram_q,
  // Fast-mode Plus drive enables.
  output logic fast_plus_drive_a2,
  output logic fast_plus_drive_b3,
  output logic fast_plus_drive_b4,
  output logic fast_plus_drive_b6
);
  // ==========================================================================
  // Boot strap sampling
  // The boot pins come from outside, so they pass two flops first.
  logic [1:0] boot_s1_q;
  logic [1:0] boot_s2_q;
  logic boot_load_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_s1_q <= 2'h0;
      boot_s2_q <= 2'h0;
    end else begin
      boot_s1_q <= boot_mode;
      boot_s2_q <= boot_s1_q;
    end
  end

  // Load pending until the synchronised strap is valid, two edges after release.
  logic [1:0] boot_cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_cnt_q <= 2'h0;
      boot_load_q <= 1'b0;
    end else if (boot_cnt_q != 2'h2) begin
      boot_cnt_q <= boot_cnt_q + 2'h1;
      boot_load_q <= (boot_cnt_q == 2'h1);
    end else begin
      boot_load_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Bus decode
  logic wr_en;
  logic rd_en;
  logic hit;
  assign hit = (paddr[11:2] == cfg_one_off[11:2]);
  assign wr_en = psel && penable && pwrite && hit;
  assign rd_en = psel && !penable && !pwrite;

  // ==========================================================================
  // Register storage
  logic [1:0] mem_sel_q;
  logic [fmp_count-1:0] fmp_q;
  logic [11:0] rsv_hi_q;
  logic [13:0] rsv_lo_q;

  // Selection: boot strap at startup, software at any time afterwards.
  // A write in the same cycle as the strap load wins, being newer intent.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_sel_q <= mem_sel_rst;
    end else if (wr_en && pstrb[0]) begin
      mem_sel_q <= pwdata[mem_sel_msb:mem_sel_lsb];
    end else if (boot_load_q) begin
      mem_sel_q <= boot_s2_q;
    end
  end

  // Drive bits and the plain read-write reserved bits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmp_q <= fmp_rst;
      rsv_hi_q <= rsv_hi_rst;
      rsv_lo_q <= 14'h0000;
    end else if (wr_en) begin
      if (pstrb[2]) begin
        fmp_q <= pwdata[fmp_msb:fmp_lsb];
        rsv_hi_q[3:0] <= pwdata[23:20];
      end
      if (pstrb[3]) begin
        rsv_hi_q[11:4] <= pwdata[31:24];
      end
      if (pstrb[0]) begin
        rsv_lo_q[5:0] <= pwdata[7:2];
      end
      if (pstrb[1]) begin
        rsv_lo_q[13:6] <= pwdata[15:8];
      end
    end
  end

  // ==========================================================================
  // Read data, registered in the setup cycle so the answer is ready in access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= hit ? {rsv_hi_q, fmp_q, rsv_lo_q, mem_sel_q} : 32'h0000_0000;
    end
  end

  // Zero wait states; an unmapped address answers with an error.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
    end
  end

  // ==========================================================================
  // Outputs
  logic dec_main;
  logic dec_sys;
  logic dec_sram;
  boot_sel_decode u_dec (
    .sel(mem_sel_q),
    .main_flash(dec_main),
    .sys_flash(dec_sys),
    .sram(dec_sram)
  );

  // Registered so that the memory select never glitches on the bus fabric.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map_main_flash_q <= 1'b1;
      map_sys_flash_q <= 1'b0;
      map_sram_q <= 1'b0;
      fast_plus_drive_a2 <= 1'b0;
      fast_plus_drive_b3 <= 1'b0;
      fast_plus_drive_b4 <= 1'b0;
      fast_plus_drive_b6 <= 1'b0;
    end else begin
      map_main_flash_q <= dec_main;
      map_sys_flash_q <= dec_sys;
      map_sram_q <= dec_sram;
      fast_plus_drive_a2 <= fmp_q[0];
      fast_plus_drive_b3 <= fmp_q[1];
      fast_plus_drive_b4 <= fmp_q[2];
      fast_plus_drive_b6 <= fmp_q[3];
    end
  end

  // ==========================================================================
  // Checks
  sequence wr_sel_s;
    psel && penable && pwrite && hit && pstrb[0];
  endsequence

  property sel_write_p;
    @(posedge pclk) disable iff (!presetn)
    wr_sel_s |=> (mem_sel_q == $past(pwdata[1:0]));
  endproperty
  chk_sel_write_takes: assert property (sel_write_p) else $error("selection write lost");

  chk_boot_load: assert property (@(posedge pclk) disable iff (!presetn)
    boot_load_q && !wr_en |=> mem_sel_q == $past(boot_s2_q)) else $error("boot strap not loaded");

  chk_map_decode: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (map_main_flash_q == !$past(mem_sel_q[0])) && (map_sram_q == ($past(mem_sel_q) == 2'b11)))
    else $error("memory map decode wrong");

  // Unlike main flash, the system flash select needs both bits set just so.
  chk_map_sys: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 map_sys_flash_q == ($past(mem_sel_q) == 2'b01)) else $error("system flash decode wrong");

  chk_fmp_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && pstrb[2] |=> ##1 fast_plus_drive_b6 == $past(pwdata[19], 2)) else $error("drive bit not applied");

  chk_fmp_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_en && pstrb[2]) |=> $stable(fmp_q)) else $error("drive bits changed without write");

  // Every pin follows its own bit, one cycle behind, so a swapped wire shows up.
  chk_drive_pins: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 {fast_plus_drive_b6, fast_plus_drive_b4, fast_plus_drive_b3, fast_plus_drive_a2} == $past(fmp_q))
    else $error("drive pins do not follow bits");

  chk_sel_read: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && hit && !boot_load_q |=> prdata[1:0] == $past(mem_sel_q)) else $error("selection read wrong");

  chk_read_back: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && hit |=> prdata[19:16] == $past(fmp_q)) else $error("drive bits read wrong");

  // Software must never see two ready pulses for one transfer.
  chk_ready_one: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready ##1 !pready) else $error("ready timing wrong");

  // An unmapped word answers at once, but with the error flag raised.
  chk_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !hit |=> pready && pslverr) else $error("unmapped access not refused");

  // The mapped word never reports an error, whatever the direction.
  chk_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && hit |=> !pslverr) else $error("mapped access refused");
endmodule
`default_nettype wire

// *** verif/tb_system_config_unit.sv ***
// Self-checking testbench for the system configuration register bank.
`timescale 1ns/1ns
`default_nettype none
module tb_system_config_unit
  import sys_cfg_pkg::*;
;
  // ==========================================================================
  // Stimulus and observed signals.
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [1:0] boot_mode = 2'b01;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, mf, sf, sr, a2, b3, b4, b6;
  logic [31:0] rd;
  logic er;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;

  // The clock runs at 50 MHz.
  always #10 pclk = ~pclk;

  system_config_unit u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .boot_mode(boot_mode), .map_main_flash_q(mf),
    .map_sys_flash_q(sf), .map_sram_q(sr), .fast_plus_drive_a2(a2), .fast_plus_drive_b3(b3),
    .fast_plus_drive_b4(b4), .fast_plus_drive_b6(b6));

  // ==========================================================================
  // Shared tasks.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; a dead slave is caught by the bench timeout, and any wait state is a mismatch.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    check("wait states", 32'(n), 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Outputs trail the register by one cycle; they are read at the edge, before the design updates them.
  task automatic pins_are(input logic [1:0] sel, input logic [3:0] fmp);
    repeat (2) @(posedge pclk);
    check("pins", {25'h0, mf, sf, sr, b6, b4, b3, a2},
      {25'h0, ~sel[0], sel == 2'b01, sel == 2'b11, fmp});
  endtask

  task automatic tally_and_finish();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the roughly 150 cycles the tests need.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // ==========================================================================
  // Test sequence.
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, cfg_one_off, 32'h0, 4'h0);
    check("reset word", rd, 32'h1);
    pins_are(2'b01, 4'h0);
    // Every selection code, each overriding the boot choice and read back.
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, cfg_one_off, 32'(s), 4'h1);
      apb(1'b0, cfg_one_off, 32'h0, 4'h0);
      check("selection", rd, 32'(s));
      pins_are(2'(s), 4'h0);
    end
    // Walk each drive bit with only its byte strobed, so the selection must survive.
    for (int b = 0; b < 4; b++) begin
      apb(1'b1, cfg_one_off, 32'h1 << (16 + b), 4'h4);
      apb(1'b0, cfg_one_off, 32'h0, 4'h0);
      check("drive bits", rd, (32'h1 << (16 + b)) | 32'h3);
      pins_are(2'b11, 4'h1 << b);
    end
    apb(1'b1, cfg_one_off, 32'hffff_ffff, 4'hf);
    apb(1'b0, cfg_one_off, 32'h0, 4'h0);
    check("full word", rd, 32'hffff_ffff);
    pins_are(2'b11, 4'hf);
    // Unmapped word: refused and without side effect.
    apb(1'b1, 12'h004, 32'h0, 4'hf);
    check("write error", {31'h0, er}, 32'h1);
    apb(1'b0, 12'h004, 32'h0, 4'h0);
    check("unmapped read", rd, 32'h0);
    check("read error", {31'h0, er}, 32'h1);
    apb(1'b0, cfg_one_off, 32'h0, 4'h0);
    check("after unmapped", rd, 32'hffff_ffff);
    // Mid-run resets under other boot straps.
    for (int k = 0; k < 2; k++) begin
      presetn <= 1'b0;
      boot_mode <= (k == 0) ? 2'b11 : 2'b10;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      apb(1'b0, cfg_one_off, 32'h0, 4'h0);
      check("strap word", rd, {30'h0, boot_mode});
      pins_are(boot_mode, 4'h0);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
